// [design/phy_regs_pkg.sv]
// Constants and types for the PHY status, identity and advertise registers
`default_nettype none
package phy_regs_pkg;
   // Register addresses, shared by the parallel port and the serial frames
   localparam int ADDR_W = 5;
   localparam int DATA_W = 16;
   localparam logic [4:0] REG_CONTROL = 5'h00;
   localparam logic [4:0] REG_STATUS = 5'h01;
   localparam logic [4:0] REG_IDENT_HI = 5'h02;
   localparam logic [4:0] REG_IDENT_LO = 5'h03;
   localparam logic [4:0] REG_ADVERTISE = 5'h04;

   // Status word fields
   localparam int ST_T4 = 15;
   localparam int ST_CAP_HI = 14;
   localparam int ST_CAP_LO = 11;
   localparam int ST_AN_DONE = 5;
   localparam int ST_RFAULT = 4;
   localparam int ST_AN_ABLE = 3;
   localparam int ST_LINK = 2;
   localparam int ST_JABBER = 1;
   localparam int ST_EXT = 0;
   localparam logic [3:0] CAP_BITS_VAL = 4'hF;
   localparam logic T4_ABLE_VAL = 1'b0;
   localparam logic AN_ABLE_VAL = 1'b1;
   localparam logic EXT_REGS_VAL = 1'b1;

   // Identity field widths
   localparam int OUI_W = 22;
   localparam int OUI_LO_W = 6;
   localparam int MODEL_W = 6;
   localparam int REV_W = 4;

   // Advertise word fields and reset values
   localparam int ADV_NP = 15;
   localparam int ADV_ACK = 14;
   localparam int ADV_RF = 13;
   localparam int ADV_RSV_HI = 12;
   localparam int ADV_RSV_LO = 11;
   localparam int ADV_PAUSE = 10;
   localparam int ADV_ABIL_HI = 9;
   localparam int ADV_ABIL_LO = 5;
   localparam int ADV_SEL_HI = 4;
   localparam int ADV_SEL_LO = 0;
   localparam logic [4:0] ADV_ABIL_RST = 5'h0F;
   localparam logic [4:0] ADV_SEL_RST = 5'h01;

   // Control word self-clearing restart bit
   localparam int CTL_RESTART = 9;

   // Serial management frame
   localparam int HDR_W = 12;
   localparam logic [1:0] OP_READ = 2'h2;
   localparam logic [1:0] OP_WRITE = 2'h1;
   localparam logic [4:0] HDR_LAST = 5'h0B;
   localparam logic [4:0] TA_LAST = 5'h01;
   localparam logic [4:0] DATA_LAST = 5'h0F;
   localparam logic [4:0] TAIL_LAST = 5'h11;
   localparam logic [4:0] PHY_ADDR_DEFAULT = 5'h01;

   typedef struct packed {
      logic an_done;
      logic remote_fault;
      logic link_up;
      logic jabber;
   } link_cond_type;

   typedef struct packed {
      logic [1:0] op;
      logic [4:0] phy;
      logic [4:0] reg_addr;
   } frame_hdr_type;

   typedef enum logic [6:0] {
      S_IDLE = 7'h01,
      S_START = 7'h02,
      S_HDR = 7'h04,
      S_TA_RD = 7'h08,
      S_RDATA = 7'h10,
      S_WDATA = 7'h20,
      S_SKIP = 7'h40
   } state_type;
endpackage
`default_nettype wire

// [design/phy_status_id_advert_regs.sv]
// PHY status, identity and advertise registers with serial management port
//
// Overview of operation
// - Status bit 15 reads 0; bits 14 to 11 read 1.
// - Status bits 10 to 6 always read zero.
// - Status bit 5 latches negotiation complete; sticky, read only.
// - Status bit 4 shows a detected remote fault.
// - Status bit 3 reads 1: negotiation is supported.
// - Status bit 2 is a sticky link valid flag.
// - Status bit 1 is a sticky jabber flag, meaningful at 10 Mbps.
// - Status bit 0 reads 1: extended registers exist.
// - A 32-bit identifier spans addresses 2 and 3.
// - Only 22 low manufacturer code bits kept; bits 23:22 are zero.
// - Code bits 21:6 fill word 1; bits 5:0 sit in word 2 15:10.
// - The 6-bit model number sits in word 2 bits 9:4.
// - The 4-bit revision sits in word 2 below the model.
// - Advertise bit 14 is read only, set by negotiation logic.
// - Advertise bit 13 is writable, resets to 0, sent as fault.
// - Advertise bit 10 is read only pause support, variant reset.
// - Advertise bits 9 to 5 writable, reset 0,1,1,1,1.
// - Advertise bits 4:0 writable selector, resets to 00001.
// - Advertise bits 12:11 are read only zero.
// - Control bit 9 written 1 restarts negotiation, then clears.
// - Registers reachable by serial frames; device drives the second turnaround bit on reads.
`default_nettype none
module phy_status_id_advert_regs
   import phy_regs_pkg::*;
#(
   parameter logic [4:0] PHY_ADDR = PHY_ADDR_DEFAULT,
   // Identity values below are arbitrary
   parameter logic [OUI_W-1:0] OUI_CODE = 22'h0A5A5A,
   parameter logic [MODEL_W-1:0] MODEL_NUM = 6'h2A,
   parameter logic [REV_W-1:0] REV_NUM = 4'h3,
   parameter logic PAUSE_ABLE = 1'b0
)(
   // Clock and reset
   input wire logic MCLK,
   input wire logic RST,
   // Register port
   input wire logic [ADDR_W-1:0] ADDR,
   input wire logic [DATA_W-1:0] WR_DATA,
   input wire logic WR_EN,
   input wire logic RD_EN,
   output logic [DATA_W-1:0] RD_DATA,
   // Negotiation and link logic
   input wire link_cond_type LINK_COND,
   input wire logic AN_ACK_SET,
   output logic [DATA_W-1:0] ADV_WORD,
   output logic RESTART_AN,
   // Serial management pins
   input wire logic MDC,
   input wire logic MDIO_IN,
   output logic MDIO_OUT,
   output logic MDIO_OE
);

   logic mdc_s1_q, mdc_s2_q, mdc_s3_q;
   logic mdi_s1_q, mdi_s2_q;
   logic mdc_rise, mdc_fall;
   state_type state_q;
   logic [4:0] cnt_q;
   frame_hdr_type hdr_q, hdr_nx;
   logic [DATA_W-1:0] shift_q;
   logic hdr_end, hdr_match;
   logic mdio_wr_q;
   logic [DATA_W-1:0] mdio_wdata_q;
   logic mdo_q, mdoe_q;
   logic wr_en;
   logic [ADDR_W-1:0] wr_addr;
   logic [DATA_W-1:0] wr_data;
   logic stat_rd;
   logic an_done_q, link_q, jabber_q;
   logic adv_np_q, adv_ack_q, adv_rf_q;
   logic [4:0] adv_abil_q, adv_sel_q;
   logic restart_q;
   logic [DATA_W-1:0] rd_data_q;
   logic [DATA_W-1:0] status_word, ident_hi, ident_lo;

   // Shared register read decode
   function automatic logic [DATA_W-1:0] read_reg(input logic [4:0] a);
      logic [DATA_W-1:0] v;
      v = '0;
      case (a)
         REG_STATUS: v = status_word;
         REG_IDENT_HI: v = ident_hi;
         REG_IDENT_LO: v = ident_lo;
         REG_ADVERTISE: v = ADV_WORD;
         default: v = '0;
      endcase
      return v;
   endfunction

   // Fixed status bits plus sticky flags
   always_comb begin
      status_word = '0;
      status_word[ST_T4] = T4_ABLE_VAL;
      status_word[ST_CAP_HI:ST_CAP_LO] = CAP_BITS_VAL;
      // reserved stay zero from the default above
      status_word[ST_AN_DONE] = an_done_q;
      status_word[ST_RFAULT] = LINK_COND.remote_fault;
      status_word[ST_AN_ABLE] = AN_ABLE_VAL;
      status_word[ST_LINK] = link_q;
      status_word[ST_JABBER] = jabber_q;
      status_word[ST_EXT] = EXT_REGS_VAL;
   end

   assign ident_hi = OUI_CODE[OUI_W-1:OUI_LO_W];
   assign ident_lo = {OUI_CODE[OUI_LO_W-1:0], MODEL_NUM, REV_NUM};

   // Advertise word as driven to negotiation logic
   always_comb begin
      ADV_WORD = '0;
      ADV_WORD[ADV_NP] = adv_np_q;
      ADV_WORD[ADV_ACK] = adv_ack_q;
      ADV_WORD[ADV_RF] = adv_rf_q;
      ADV_WORD[ADV_RSV_HI:ADV_RSV_LO] = 2'h0;
      ADV_WORD[ADV_PAUSE] = PAUSE_ABLE;
      ADV_WORD[ADV_ABIL_HI:ADV_ABIL_LO] = adv_abil_q;
      ADV_WORD[ADV_SEL_HI:ADV_SEL_LO] = adv_sel_q;
   end

   // Pin synchronisers
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         mdc_s1_q <= 1'b0;
         mdc_s2_q <= 1'b0;
         mdc_s3_q <= 1'b0;
         mdi_s1_q <= 1'b1;
         mdi_s2_q <= 1'b1;
      end else begin
         mdc_s1_q <= MDC;
         mdc_s2_q <= mdc_s1_q;
         mdc_s3_q <= mdc_s2_q;
         mdi_s1_q <= MDIO_IN;
         mdi_s2_q <= mdi_s1_q;
      end
   end

   assign mdc_rise = mdc_s2_q & ~mdc_s3_q;
   assign mdc_fall = ~mdc_s2_q & mdc_s3_q;
   assign hdr_nx = frame_hdr_type'({hdr_q[HDR_W-2:0], mdi_s2_q});
   assign hdr_end = mdc_rise && (state_q == S_HDR) && (cnt_q == HDR_LAST);
   assign hdr_match = (hdr_nx.phy == PHY_ADDR);

   // frame sequencer on the sampled clock edges
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         state_q <= S_IDLE;
         cnt_q <= '0;
         hdr_q <= '0;
         shift_q <= '0;
      end else if (mdc_rise) begin
         case (state_q)
            S_IDLE: begin
               if (!mdi_s2_q) begin
                  state_q <= S_START;
               end
            end
            S_START: begin
               if (mdi_s2_q) begin
                  state_q <= S_HDR;
                  cnt_q <= '0;
               end
            end
            S_HDR: begin
               hdr_q <= hdr_nx;
               cnt_q <= cnt_q + 5'h01;
               if (cnt_q == HDR_LAST) begin
                  cnt_q <= '0;
                  if (hdr_match && hdr_nx.op == OP_READ) begin
                     state_q <= S_TA_RD;
                     shift_q <= read_reg(hdr_nx.reg_addr);
                  end else if (hdr_match && hdr_nx.op == OP_WRITE) begin
                     state_q <= S_WDATA;
                  end else begin
                     state_q <= S_SKIP;
                  end
               end
            end
            S_TA_RD: begin
               cnt_q <= cnt_q + 5'h01;
               if (cnt_q == TA_LAST) begin
                  state_q <= S_RDATA;
                  cnt_q <= '0;
               end
            end
            S_RDATA: begin
               cnt_q <= cnt_q + 5'h01;
               if (cnt_q == DATA_LAST) begin
                  state_q <= S_IDLE;
               end
            end
            S_WDATA: begin
               shift_q <= {shift_q[DATA_W-2:0], mdi_s2_q};
               cnt_q <= cnt_q + 5'h01;
               if (cnt_q == TAIL_LAST) begin
                  state_q <= S_IDLE;
               end
            end
            S_SKIP: begin
               cnt_q <= cnt_q + 5'h01;
               if (cnt_q == TAIL_LAST) begin
                  state_q <= S_IDLE;
               end
            end
            default: begin
               state_q <= S_IDLE;
            end
         endcase
      end else if (mdc_fall && state_q == S_RDATA) begin
         shift_q <= {shift_q[DATA_W-2:0], 1'b0};
      end
   end

   // device drives turnaround zero and read data on falling edges
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         mdo_q <= 1'b0;
         mdoe_q <= 1'b0;
      end else if (mdc_fall) begin
         if (state_q == S_TA_RD && cnt_q == TA_LAST) begin
            mdo_q <= 1'b0;
            mdoe_q <= 1'b1;
         end else if (state_q == S_RDATA) begin
            mdo_q <= shift_q[DATA_W-1];
            mdoe_q <= 1'b1;
         end else begin
            mdo_q <= 1'b0;
            mdoe_q <= 1'b0;
         end
      end
   end

   assign MDIO_OUT = mdo_q;
   assign MDIO_OE = mdoe_q;

   // Serial write commits one cycle after the last data bit
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         mdio_wr_q <= 1'b0;
         mdio_wdata_q <= '0;
      end else begin
         mdio_wr_q <= mdc_rise && state_q == S_WDATA && cnt_q == TAIL_LAST;
         if (mdc_rise && state_q == S_WDATA && cnt_q == TAIL_LAST) begin
            mdio_wdata_q <= {shift_q[DATA_W-2:0], mdi_s2_q};
         end
      end
   end

   // Port write takes precedence over a serial write in the same cycle
   assign wr_en = WR_EN | mdio_wr_q;
   assign wr_addr = WR_EN ? ADDR : hdr_q.reg_addr;
   assign wr_data = WR_EN ? WR_DATA : mdio_wdata_q;
   assign stat_rd = (RD_EN && ADDR == REG_STATUS) ||
                    (hdr_end && hdr_match && hdr_nx.op == OP_READ &&
                     hdr_nx.reg_addr == REG_STATUS);

   // sticky flags follow the condition after a status read
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         an_done_q <= 1'b0;
         link_q <= 1'b0;
         jabber_q <= 1'b0;
      end else begin
         an_done_q <= stat_rd ? LINK_COND.an_done
                              : (an_done_q | LINK_COND.an_done);
         link_q <= stat_rd ? LINK_COND.link_up
                           : (link_q & LINK_COND.link_up);
         jabber_q <= stat_rd ? LINK_COND.jabber
                             : (jabber_q | LINK_COND.jabber);
      end
   end

   // Advertise register
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         adv_np_q <= 1'b0;
         adv_rf_q <= 1'b0;
         adv_abil_q <= ADV_ABIL_RST;
         adv_sel_q <= ADV_SEL_RST;
      end else if (wr_en && wr_addr == REG_ADVERTISE) begin
         adv_np_q <= wr_data[ADV_NP];
         adv_rf_q <= wr_data[ADV_RF];
         adv_abil_q <= wr_data[ADV_ABIL_HI:ADV_ABIL_LO];
         adv_sel_q <= wr_data[ADV_SEL_HI:ADV_SEL_LO];
      end
   end

   // acknowledge set only by negotiation, dropped on restart
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         adv_ack_q <= 1'b0;
      end else if (AN_ACK_SET) begin
         adv_ack_q <= 1'b1;
      end else if (restart_q) begin
         adv_ack_q <= 1'b0;
      end
   end

   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         restart_q <= 1'b0;
      end else begin
         restart_q <= wr_en && wr_addr == REG_CONTROL &&
                      wr_data[CTL_RESTART];
      end
   end

   assign RESTART_AN = restart_q;

   // Port read data stands one cycle only
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         rd_data_q <= '0;
      end else begin
         rd_data_q <= RD_EN ? read_reg(ADDR) : '0;
      end
   end

   assign RD_DATA = rd_data_q;

   default clocking cb @(posedge MCLK); endclocking
   default disable iff (RST);

   a_status_fixed: assert property (
      RD_EN && ADDR == REG_STATUS |=> RD_DATA[15:11] == 5'h0F &&
      RD_DATA[10:6] == 5'h00 && RD_DATA[3] && RD_DATA[0])
      else $error("fixed status bits wrong");
   a_link_drop: assert property (
      !LINK_COND.link_up |=> !link_q ##1 (!link_q || stat_rd ||
      $past(stat_rd)) )
      else $error("link loss not latched");
   a_jabber_hold: assert property (
      jabber_q && !stat_rd |=> jabber_q)
      else $error("jabber flag lost before read");
   a_an_done_set: assert property (
      LINK_COND.an_done |=> RD_EN && ADDR == REG_STATUS |=> RD_DATA[5])
      else $error("completion not reported");
   a_ident_low: assert property (
      RD_EN && ADDR == REG_IDENT_LO |=>
      RD_DATA == {OUI_CODE[5:0], MODEL_NUM, REV_NUM})
      else $error("identifier word 2 wrong");
   a_adv_reserved: assert property (
      ADV_WORD[12:11] == 2'h0 && ADV_WORD[10] == PAUSE_ABLE)
      else $error("advertise read-only bits wrong");
   a_ack_readonly: assert property (
      !AN_ACK_SET && !restart_q |=> $stable(ADV_WORD[14]))
      else $error("acknowledge changed without cause");
   a_adv_write: assert property (
      WR_EN && ADDR == REG_ADVERTISE |=>
      ADV_WORD[9:0] == $past(WR_DATA[9:0]) &&
      ADV_WORD[13] == $past(WR_DATA[13]))
      else $error("advertise write not stored");
   a_restart_pulse: assert property (
      WR_EN && ADDR == REG_CONTROL && WR_DATA[9] |=> RESTART_AN
      ##1 (!RESTART_AN || $past(wr_en)))
      else $error("restart pulse wrong");
   a_ta_zero: assert property (
      $rose(MDIO_OE) |-> !MDIO_OUT && $past(state_q) == S_TA_RD)
      else $error("turnaround not driven low");
   a_idle_release: assert property (
      state_q == S_IDLE && mdc_fall |=> !MDIO_OE)
      else $error("pin held after frame");

   c_status_read: cover property (RD_EN && ADDR == REG_STATUS);
   c_serial_read: cover property (state_q == S_RDATA ##1 state_q == S_IDLE);
   c_serial_write: cover property (mdio_wr_q);
   c_restart: cover property (RESTART_AN);

endmodule
`default_nettype wire

// [tb/mdio_master_model.sv]
// Management controller model driving serial frames on MDC and MDIO
`default_nettype none
module mdio_master_model
   import phy_regs_pkg::*;
(
   // Serial management pins
   output logic mdc,
   output wire logic mdio_in,
   input wire logic mdio_out,
   input wire logic mdio_oe
);
   timeunit 1ns;
   timeprecision 100ps;
   logic ctl_oe;
   logic ctl_val;

   // Wire level: device, controller, else pull-up
   assign mdio_in = mdio_oe ? mdio_out : (ctl_oe ? ctl_val : 1'b1);

   initial begin
      mdc = 1'b0;
      ctl_oe = 1'b0;
      ctl_val = 1'b1;
   end

   // One 80 ns bit; sample mid high phase for sync delay margin
   task automatic clk_bit(input logic b, output logic s);
      ctl_val = b;
      #40 mdc = 1'b1;
      #20 s = mdio_in;
      #20 mdc = 1'b0;
   endtask

   // controller drives start, opcode and addresses
   task automatic frame(input logic [1:0] op, input logic [4:0] phy,
                        input logic [4:0] ra, input logic [15:0] wd,
                        output logic [15:0] rd, output logic ta0);
      logic [21:0] hdr;
      logic s;
      hdr = {8'hFF, 2'h1, op, phy, ra};
      ctl_oe = 1'b1;
      for (int i = 21; i >= 0; i--) begin
         clk_bit(hdr[i], s);
      end
      if (op == OP_READ) begin
         ctl_oe = 1'b0;
      end
      clk_bit(1'b1, s);
      clk_bit(1'b0, ta0);
      for (int i = 15; i >= 0; i--) begin
         clk_bit(wd[i], s);
         rd[i] = s;
      end
      ctl_oe = 1'b0;
   endtask
endmodule
`default_nettype wire

// [tb/phy_status_id_advert_regs_test.sv]
// Self-checking bench for the PHY status, identity and advertise registers
`default_nettype none
module phy_status_id_advert_regs_test
   import phy_regs_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   // Identity values are arbitrary
   localparam logic [21:0] OUI_V = 22'h2D3C1B;
   localparam logic [5:0] MOD_V = 6'h1C;
   localparam logic [3:0] REV_V = 4'h9;
   localparam logic [15:0] ID_LO = {OUI_V[5:0], MOD_V, REV_V};
   logic mclk, rst, wr_en, rd_en, ack_set, restart_an;
   logic [4:0] addr;
   logic [15:0] wr_data, rd_data, adv_word;
   link_cond_type cond;
   logic mdc, mdio_in, mdio_out, mdio_oe;
   int err_count = 0;
   int checked = 0;

   phy_status_id_advert_regs #(.OUI_CODE(OUI_V), .MODEL_NUM(MOD_V),
      .REV_NUM(REV_V)) uut (
      .MCLK(mclk), .RST(rst), .ADDR(addr), .WR_DATA(wr_data),
      .WR_EN(wr_en), .RD_EN(rd_en), .RD_DATA(rd_data),
      .LINK_COND(cond), .AN_ACK_SET(ack_set), .ADV_WORD(adv_word),
      .RESTART_AN(restart_an), .MDC(mdc), .MDIO_IN(mdio_in),
      .MDIO_OUT(mdio_out), .MDIO_OE(mdio_oe));

   mdio_master_model mdm (.mdc(mdc), .mdio_in(mdio_in),
      .mdio_out(mdio_out), .mdio_oe(mdio_oe));

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   task automatic final_report;
      $display("Comparisons %0d, mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [15:0] seen,
                        input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic reg_write(input logic [4:0] a, input logic [15:0] d);
      @(posedge mclk);
      addr <= a;
      wr_data <= d;
      wr_en <= 1'b1;
      @(posedge mclk);
      wr_en <= 1'b0;
   endtask

   task automatic rd_chk(input logic [4:0] a, input logic [15:0] exp,
                         input string what);
      @(posedge mclk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge mclk);
      rd_en <= 1'b0;
      #1 check(what, rd_data, exp);
   endtask

   initial begin
      repeat (100000) @(posedge mclk);
      err_count++;
      final_report();
   end

   initial begin
      logic [15:0] d;
      logic ta;
      rst = 1'b1;
      addr = 5'h00;
      wr_data = 16'h0000;
      wr_en = 1'b0;
      rd_en = 1'b0;
      cond = 4'h0;
      ack_set = 1'b0;
      repeat (4) @(posedge mclk);
      rst <= 1'b0;
      rd_chk(REG_STATUS, 16'h7809, "stat");
      rd_chk(REG_IDENT_HI, OUI_V[21:6], "ident hi");
      rd_chk(REG_IDENT_LO, ID_LO, "ident lo");
      rd_chk(REG_ADVERTISE, 16'h01E1, "adv");
      check("adv word", adv_word, 16'h01E1);
      rd_chk(5'h1F, 16'h0000, "unmapped");
      rd_chk(REG_CONTROL, 16'h0000, "control");
      $display("test reset values done");
      // T4 flag left clear: the device cannot do T4
      reg_write(REG_ADVERTISE, 16'h7DFF);
      rd_chk(REG_ADVERTISE, 16'h21FF, "adv");
      check("adv word", adv_word, 16'h21FF);
      reg_write(REG_ADVERTISE, 16'h0000);
      rd_chk(REG_ADVERTISE, 16'h0000, "adv");
      reg_write(REG_STATUS, 16'h0000);
      rd_chk(REG_STATUS, 16'h7809, "status");
      @(posedge mclk);
      ack_set <= 1'b1;
      @(posedge mclk);
      ack_set <= 1'b0;
      rd_chk(REG_ADVERTISE, 16'h4000, "adv ack");
      reg_write(REG_CONTROL, 16'h0200);
      #1 check("restart", {15'h0000, restart_an}, 16'h0001);
      @(posedge mclk);
      #1 check("restart", {15'h0000, restart_an}, 16'h0000);
      rd_chk(REG_ADVERTISE, 16'h0000, "adv ack");
      $display("test advertise done");
      @(posedge mclk);
      cond <= 4'hA;
      repeat (2) @(posedge mclk);
      rd_chk(REG_STATUS, 16'h7829, "status");
      rd_chk(REG_STATUS, 16'h782D, "status");
      @(posedge mclk);
      cond <= 4'h1;
      @(posedge mclk);
      cond <= 4'h6;
      repeat (2) @(posedge mclk);
      rd_chk(REG_STATUS, 16'h783B, "status");
      rd_chk(REG_STATUS, 16'h781D, "status");
      $display("test sticky flags done");
      mdm.frame(OP_READ, PHY_ADDR_DEFAULT, REG_STATUS, 16'h0000, d, ta);
      check("serial status", d, 16'h781D);
      check("turnaround", {15'h0000, ta}, 16'h0000);
      mdm.frame(OP_READ, PHY_ADDR_DEFAULT, REG_IDENT_LO, 16'h0000, d, ta);
      check("serial ident", d, ID_LO);
      mdm.frame(OP_WRITE, PHY_ADDR_DEFAULT, REG_ADVERTISE, 16'h0021, d, ta);
      repeat (10) @(posedge mclk);
      check("adv word", adv_word, 16'h0021);
      rd_chk(REG_ADVERTISE, 16'h0021, "adv");
      reg_write(REG_CONTROL, 16'h0200);
      #1 check("restart", {15'h0000, restart_an}, 16'h0001);
      mdm.frame(OP_READ, 5'h07, REG_STATUS, 16'h0000, d, ta);
      check("foreign frame", d, 16'hFFFF);
      check("turnaround", {15'h0000, ta}, 16'h0001);
      repeat (10) @(posedge mclk);
      check("pin enable", {15'h0000, mdio_oe}, 16'h0000);
      $display("test serial frames done");
      final_report();
   end
endmodule
`default_nettype wire
